// file: common/alpha_pkg.sv
// How it works
// (RQ1) lead byte 80: each following byte pair is one code point, first byte high
// (RQ2) in the pair form, FF padding and a lone trailing byte emit nothing
// (RQ3) lead 81: byte two is the count, byte three forms base bits 14..7
// (RQ4) lead 81 body: top bit clear gives 7-bit char, set gives base plus offset
// (RQ5) lead 82: byte two is the count, bytes three and four the full base
// (RQ6) lead 82 body from byte five: same split on the top bit as lead 81
// (RQ7) compressed forms decode exactly count bytes; FF inside the count is a character
// (RQ8) one scheme per field, chosen from the lead byte, held to the field end
// (RQ9) all three marked forms are served regardless of the character set size
// (RQ10) any other lead byte: every byte passes as an 8-bit char, one per cycle
// (RQ11) a count longer than the field raises an error at its last byte; the bytes it did carry are still output
package alpha_pkg;
  localparam logic [7:0] LEAD_PAIR = 8'h80;
  localparam logic [7:0] LEAD_HALF = 8'h81;
  localparam logic [7:0] LEAD_FULL = 8'h82;
  localparam logic [7:0] CNT_NONE = 8'h00;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [15:0] PAD_PAIR = 16'hFFFF;
  localparam int CODE_W = 16;
  localparam int BYTE_W = 8;
  localparam int OFS_W = 7;
  localparam int FLAG_BIT = 7;
  localparam int BASE_SHIFT = 7;
  localparam int FIFO_DEPTH_DEF = 8;

  typedef enum logic [1:0] {SCH_PLAIN, SCH_PAIR, SCH_HALF, SCH_FULL} scheme_t;

  typedef struct packed {
    logic ucs2;
    logic [CODE_W-1:0] code;
  } char_t;

  localparam int CHAR_W = $bits(char_t);
endpackage

// file: common/char_if.sv
`timescale 1ns/1ps
// one decoded character with its handshake, between decoder core and buffer
interface char_if;
  import alpha_pkg::*;
  logic valid;
  logic ready;
  char_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: logic/offset_map.sv
`timescale 1ns/1ps
// turns a body byte of a compressed field into a character
module offset_map (
  input wire logic [alpha_pkg::CODE_W-1:0] base,
  input wire logic [alpha_pkg::BYTE_W-1:0] body_byte,
  output alpha_pkg::char_t chr
);
  import alpha_pkg::*;

  // top bit picks the half page; the add never wraps for a legal base
  always_comb begin
    chr.ucs2 = body_byte[FLAG_BIT]; // RQ4 RQ6
    if (body_byte[FLAG_BIT]) begin
      chr.code = base + {{(CODE_W-OFS_W){1'b0}}, body_byte[OFS_W-1:0]}; // RQ4 RQ6
    end else begin
      chr.code = {{(CODE_W-OFS_W){1'b0}}, body_byte[OFS_W-1:0]};
    end
  end
endmodule

// file: logic/char_fifo.sv
`timescale 1ns/1ps
// flip-flop fifo; ready on the write side drops when full so the source stalls
module char_fifo #(
  parameter int WIDTH = alpha_pkg::CHAR_W,
  parameter int DEPTH = alpha_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  char_if.snk wr,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  import alpha_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH != CHAR_W) begin
      $error("char_fifo: depth must be a power of two, width must match");
    end
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic do_wr, do_rd;

  assign wr.ready = (cnt_r != DEPTH[AW:0]);
  assign rd_valid = (cnt_r != '0);
  assign rd_data = mem_r[rp_r];
  assign do_wr = wr.valid && wr.ready;
  assign do_rd = rd_valid && rd_ready;

  // pointer and storage next values
  always_comb begin
    mem_nxt = mem_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (do_wr) begin
      mem_nxt[wp_r] = wr.data;
      wp_nxt = wp_r + 1'b1;
    end
    if (do_rd) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (!do_wr && do_rd) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // storage and pointers; storage resets too so the data outputs never show unknowns
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end
endmodule

// file: logic/ucs2_alpha_field_decoder.sv
`timescale 1ns/1ps
// alpha field decoder: bytes of one record in, characters out through a fifo
module ucs2_alpha_field_decoder #(
  parameter int FIFO_DEPTH = alpha_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [alpha_pkg::BYTE_W-1:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_ucs2,
  output logic [alpha_pkg::CODE_W-1:0] out_code,
  output logic [1:0] field_scheme,
  output logic field_busy,
  output logic field_done,
  output logic decode_err
);
  import alpha_pkg::*;
  // field layouts served, by lead byte:
  //   80: code points as byte pairs, first byte of a pair high
  //   81: count, one base byte, then count body bytes
  //   82: count, base high byte, base low byte, then count body bytes
  //   other: the whole field, lead included, is plain characters
  // a body byte with its top bit clear is a plain 7-bit character; with it
  // set, its low seven bits are an offset from the base
  //
  // the field is framed by in_last alone; no length is carried separately,
  // so a count that runs past in_last can only be noticed at in_last
  //
  // limitations a user should know:
  //   - plain fields pass all eight bits; translating them to glyphs is
  //     left to the consumer
  //   - in the pair form a pair of two filler bytes is dropped as a whole;
  //     a single filler byte inside a pair still forms a code point
  //   - bytes past the count in a compressed field are swallowed unseen
  //   - the error flag stays up until the next field's lead byte
  //
  // throughput: one byte per cycle while the buffer has room; the buffer
  // ready gates every byte, also header and filler bytes, so a full buffer
  // stalls the whole field rather than letting silent bytes slip by
  //
  // status outputs: field_scheme shows the scheme of the current or last
  // field, field_busy is high between the first and the last byte of a
  // field, field_done pulses for one cycle after the last byte, and
  // decode_err reports a count that the field could not supply
  //
  // the decode is purely per byte with no look-ahead, which keeps the
  // path from in_data to the buffer short at the price of noticing a
  // short field only when its last byte arrives

  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("ucs2_alpha_field_decoder: fifo depth below two");
    end
  end

  // sequencer states:
  //   ST_LEAD    waiting for the first byte of a field
  //   ST_PLAIN   unmarked field, every byte is a character
  //   ST_PAIR_HI pair form, holding the high byte of a code point
  //   ST_PAIR_LO pair form, low byte completes the code point
  //   ST_COUNT   compressed form, character count byte
  //   ST_BASE_A  base byte (half page) or base high byte (full base)
  //   ST_BASE_B  full base only, base low byte
  //   ST_BODY    counted body bytes, one character each
  //   ST_SKIP    filler after the count, dropped up to in_last
  typedef enum logic [3:0] {
    ST_LEAD,
    ST_PLAIN,
    ST_PAIR_HI,
    ST_PAIR_LO,
    ST_COUNT,
    ST_BASE_A,
    ST_BASE_B,
    ST_BODY,
    ST_SKIP
  } state_t;

  // sequencer state and the field header collected so far
  state_t st_r, st_nxt;
  scheme_t sch_r, sch_nxt;
  logic [BYTE_W-1:0] hi_r, hi_nxt;
  logic [BYTE_W-1:0] cnt_r, cnt_nxt;
  logic [CODE_W-1:0] base_r, base_nxt;
  logic err_r, err_nxt;
  logic done_r, done_nxt;
  logic busy_r, busy_nxt;
  // per-byte handshake and the character the byte may produce
  logic take;
  logic emit;
  char_t emit_chr;
  char_t body_chr;
  logic [CHAR_W-1:0] rd_word;
  char_t rd_chr;
  logic lead_pair;
  logic lead_half;
  logic lead_full;
  logic lead_marked;

  char_if cq ();

  // body bytes of either compressed form go through the same half-page mapper
  // the base register is steady while body bytes flow, so the add sees a fixed base
  offset_map u_map (
    .base(base_r),
    .body_byte(in_data),
    .chr(body_chr)
  );

  // the buffer stands between decoder and consumer; a full buffer stalls input
  char_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr(cq.snk),
    .rd_valid(out_valid),
    .rd_ready(out_ready),
    .rd_data(rd_word)
  );

  // input is held whenever the buffer cannot take a character, even for
  // bytes that emit nothing; costs a cycle now and then, keeps timing simple
  assign in_ready = cq.ready;
  assign take = in_valid && in_ready;
  assign cq.valid = in_valid && emit;
  assign cq.data = emit_chr;

  assign rd_chr = char_t'(rd_word);
  assign out_ucs2 = rd_chr.ucs2;
  assign out_code = rd_chr.code;
  assign field_scheme = sch_r;
  assign field_busy = busy_r;
  assign field_done = done_r;
  assign decode_err = err_r;

  // lead byte classes, shared by the emit path and the sequencer so both
  // always agree on whether a field is marked
  assign lead_pair = (in_data == LEAD_PAIR);
  assign lead_half = (in_data == LEAD_HALF);
  assign lead_full = (in_data == LEAD_FULL);
  assign lead_marked = lead_pair || lead_half || lead_full;

  // what the current byte would emit, decided by state and the byte itself
  // the character enters the buffer on the edge that takes its byte, so
  // there is no extra stage between input and buffer
  always_comb begin
    emit = 1'b0;
    emit_chr = '0;
    unique case (st_r)
      ST_LEAD: begin
        if (!lead_marked) begin
          emit = 1'b1; // RQ10
          emit_chr.code = {{(CODE_W-BYTE_W){1'b0}}, in_data};
        end
      end
      ST_PLAIN: begin
        emit = 1'b1; // RQ10
        emit_chr.code = {{(CODE_W-BYTE_W){1'b0}}, in_data};
      end
      ST_PAIR_LO: begin
        // an all-padding pair is filler, not a character
        emit = ({hi_r, in_data} != PAD_PAIR); // RQ2
        emit_chr.ucs2 = 1'b1;
        emit_chr.code = {hi_r, in_data}; // RQ1
      end
      ST_BODY: begin
        // every counted byte is a character, FF included
        emit = 1'b1; // RQ7
        emit_chr = body_chr;
      end
      ST_PAIR_HI, ST_COUNT, ST_BASE_A, ST_BASE_B, ST_SKIP: begin
        emit = 1'b0;
      end
    endcase
  end

  // field sequencer: scheme fixed at the lead byte, released at the last byte
  always_comb begin
    st_nxt = st_r;
    sch_nxt = sch_r;
    hi_nxt = hi_r;
    cnt_nxt = cnt_r;
    base_nxt = base_r;
    err_nxt = err_r;
    done_nxt = 1'b0;
    busy_nxt = busy_r;
    if (take) begin
      busy_nxt = !in_last;
      done_nxt = in_last;
      unique case (st_r)
        ST_LEAD: begin
          err_nxt = 1'b0; // a fresh field clears the last field's error
          base_nxt = '0;
          cnt_nxt = CNT_NONE;
          // all three marked forms are always decoded
          if (lead_pair) begin // RQ9
            sch_nxt = SCH_PAIR; // RQ8
            st_nxt = ST_PAIR_HI;
          end else if (lead_half) begin
            sch_nxt = SCH_HALF; // RQ8
            st_nxt = ST_COUNT;
            // a marked lead that is also the last byte carries no count at all
            err_nxt = in_last; // RQ11
          end else if (lead_full) begin
            sch_nxt = SCH_FULL; // RQ8
            st_nxt = ST_COUNT;
            err_nxt = in_last; // RQ11
          end else begin
            sch_nxt = SCH_PLAIN; // RQ10
            st_nxt = ST_PLAIN;
          end
        end
        ST_PLAIN: begin
          st_nxt = ST_PLAIN;
        end
        ST_PAIR_HI: begin
          // a lone byte at the field end is the unusable tail
          hi_nxt = in_data; // RQ2
          st_nxt = ST_PAIR_LO;
        end
        ST_PAIR_LO: begin
          st_nxt = ST_PAIR_HI; // RQ1
        end
        ST_COUNT: begin
          // a count of zero is legal: the field then carries no body
          cnt_nxt = in_data; // RQ3 RQ5
          st_nxt = ST_BASE_A;
          if (in_last && in_data != CNT_NONE) begin
            err_nxt = 1'b1; // RQ11
          end
        end
        ST_BASE_A: begin
          if (sch_r == SCH_HALF) begin
            // half page: bit 15 and the low seven bits stay clear
            base_nxt = {1'b0, in_data, {BASE_SHIFT{1'b0}}}; // RQ3
            st_nxt = (cnt_r == CNT_NONE) ? ST_SKIP : ST_BODY; // RQ7
          end else begin
            base_nxt = {in_data, {BYTE_W{1'b0}}}; // RQ5
            st_nxt = ST_BASE_B;
          end
          if (in_last && cnt_r != CNT_NONE) begin
            err_nxt = 1'b1; // RQ11
          end
        end
        ST_BASE_B: begin
          base_nxt = {base_r[CODE_W-1:BYTE_W], in_data}; // RQ5
          st_nxt = (cnt_r == CNT_NONE) ? ST_SKIP : ST_BODY; // RQ7
          if (in_last && cnt_r != CNT_NONE) begin
            err_nxt = 1'b1; // RQ11
          end
        end
        ST_BODY: begin
          // count down per body byte; the byte seen at one is the last counted
          cnt_nxt = cnt_r - CNT_ONE; // RQ7
          if (cnt_r == CNT_ONE) begin
            st_nxt = ST_SKIP; // RQ7
          end
          if (in_last && cnt_r != CNT_ONE) begin
            err_nxt = 1'b1; // RQ11
          end
        end
        ST_SKIP: begin
          // bytes past the count are filler; nothing is emitted
          st_nxt = ST_SKIP; // RQ7
        end
      endcase
      // the last byte always closes the field, whatever the state; a
      // compressed field cut short has already raised its error above
      if (in_last) begin
        st_nxt = ST_LEAD; // RQ8
      end
    end
  end

  // sequencer registers; reset leaves a plain scheme and no open field
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_LEAD;
      sch_r <= SCH_PLAIN;
      hi_r <= '0;
      cnt_r <= '0;
      base_r <= '0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sch_r <= sch_nxt;
      hi_r <= hi_nxt;
      cnt_r <= cnt_nxt;
      base_r <= base_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      busy_r <= busy_nxt;
    end
  end
endmodule

// file: verification/alpha_dec_props.sv
`timescale 1ns/1ps
// port-level checks on the field decoder
module alpha_dec_props (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_ucs2,
  input wire logic [15:0] out_code,
  input wire logic [1:0] field_scheme,
  input wire logic field_busy,
  input wire logic field_done,
  input wire logic decode_err
);
  import alpha_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic take_w;
  logic lead_w;
  logic [1:0] sch_w;
  // a lead byte is any byte taken while no field is open
  assign take_w = in_valid && in_ready;
  assign lead_w = take_w && !field_busy;
  assign sch_w = (in_data == LEAD_PAIR) ? 2'h1 : (in_data == LEAD_HALF) ? 2'h2 :
    (in_data == LEAD_FULL) ? 2'h3 : 2'h0;
  chk_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_code) && $stable(out_ucs2)) else $error("output moved while held");
  chk_scheme_pick: assert property (lead_w |=> field_scheme == $past(sch_w))
    else $error("scheme not taken from lead byte");
  chk_scheme_hold: assert property (field_busy |=> $stable(field_scheme))
    else $error("scheme switched inside a field");
  chk_done_after: assert property (take_w && in_last |=> field_done && !field_busy)
    else $error("no done after last byte");
  chk_done_cause: assert property (field_done |-> $past(take_w && in_last))
    else $error("done without a last byte");
  chk_busy_open: assert property (take_w && !in_last |=> field_busy)
    else $error("busy missing inside field");
  chk_err_clear: assert property (lead_w && !in_last |=> !decode_err)
    else $error("error not cleared by lead byte");
  chk_err_hold: assert property (decode_err && !lead_w |=> decode_err)
    else $error("error dropped inside field");
  chk_char_low: assert property (out_valid && !out_ucs2 |-> out_code[15:8] == 8'h00)
    else $error("plain char with high bits");
  chk_full_nonempty: assert property (!in_ready |-> out_valid)
    else $error("stall with empty buffer");
  cover property (lead_w && in_data == LEAD_HALF);
  cover property (decode_err);
  cover property (!in_ready);
endmodule
bind ucs2_alpha_field_decoder alpha_dec_props chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
  .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_ucs2(out_ucs2), .out_code(out_code),
  .field_scheme(field_scheme), .field_busy(field_busy), .field_done(field_done),
  .decode_err(decode_err));

// file: verification/field_src.sv
`timescale 1ns/1ps
// record reader model: offers a field byte by byte, each held until taken
module field_src (
  input wire logic clk_sys,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_last
);
  // nothing offered from time zero
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
  end
  // released bus shows the inverse byte so a stale read cannot pass
  task automatic send(input logic [7:0] b[$], input int gap);
    for (int i = 0; i < b.size(); i++) begin
      in_valid <= 1'b1;
      in_data <= b[i];
      in_last <= (i == b.size() - 1);
      // ready settles mid-cycle; reading it at the rising edge would race the buffer
      @(negedge clk_sys);
      while (in_ready !== 1'b1) @(negedge clk_sys);
      @(posedge clk_sys);
      if (gap > 0) begin
        in_valid <= 1'b0;
        in_data <= ~b[i];
        repeat (gap) @(posedge clk_sys);
      end
    end
    in_valid <= 1'b0;
    in_data <= ~b[b.size() - 1];
    in_last <= 1'b0;
  endtask
endmodule

// file: verification/ucs2_alpha_field_decoder_tb.sv
`timescale 1ns/1ps
module ucs2_alpha_field_decoder_tb;
  import alpha_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic out_ready = 1'b1;
  logic in_valid, in_last, in_ready, out_valid, out_ucs2;
  logic field_busy, field_done, decode_err;
  logic [7:0] in_data;
  logic [15:0] out_code;
  logic [1:0] field_scheme;
  logic [16:0] got[$];
  int bad_count = 0;
  int tests_run = 0;
  int done_seen = 0;
  field_src src_u (.clk_sys(clk_sys), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last));
  ucs2_alpha_field_decoder dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_ucs2(out_ucs2), .out_code(out_code),
    .field_scheme(field_scheme), .field_busy(field_busy), .field_done(field_done),
    .decode_err(decode_err));
  // 25 ns clock
  always #12.5 clk_sys = ~clk_sys;
  // collect every character the consumer takes; looked at mid-cycle, where the
  // values that the next rising edge will use have settled
  always @(negedge clk_sys) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back({out_ucs2, out_code});
    if (field_done === 1'b1) done_seen++;
  end
  task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] seen);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask
  // bounded wait, then a few spare cycles so extra characters get counted
  task automatic expect_all(input logic [16:0] e[$]);
    int n;
    n = 0;
    while (got.size() < e.size() && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    chk("count", 17'(e.size()), 17'(got.size()));
    foreach (e[i]) chk("char", e[i], got[i]);
  endtask
  task automatic run(input logic [7:0] b[$], input logic [16:0] e[$], input int gap);
    int d0;
    d0 = done_seen;
    got.delete();
    src_u.send(b, gap);
    expect_all(e);
    chk("done", 17'(d0 + 1), 17'(done_seen));
    chk("busy", 17'h0, {16'h0, field_busy});
  endtask
  task automatic t_pair;
    run('{8'h80, 8'h00, 8'h41, 8'h09, 8'h95, 8'hFF, 8'hFF, 8'hFF},
      '{17'h10041, 17'h10995}, 0);
    chk("scheme", 17'h1, {15'h0, field_scheme});
  endtask
  task automatic t_half;
    run('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h58, 8'hFF, 8'hFF},
      '{17'h00053, 17'h10995, 17'h109A6, 17'h00058, 17'h109FF}, 0);
    chk("scheme", 17'h2, {15'h0, field_scheme});
  endtask
  task automatic t_full;
    run('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31},
      '{17'h0002D, 17'h10532, 17'h10583, 17'h0002D, 17'h00031}, 2);
    chk("scheme", 17'h3, {15'h0, field_scheme});
  endtask
  task automatic t_err;
    run('{8'h81, 8'h04, 8'h13, 8'h41, 8'hC1}, '{17'h00041, 17'h109C1}, 0);
    chk("err", 17'h1, {16'h0, decode_err});
  endtask
  task automatic t_plain;
    run('{8'h41, 8'h42, 8'hFF}, '{17'h00041, 17'h00042, 17'h000FF}, 0);
    chk("err", 17'h0, {16'h0, decode_err});
    chk("scheme", 17'h0, {15'h0, field_scheme});
  endtask
  // a field ending after its header with a nonzero count, a zero count, and pair padding mixed with real pairs
  task automatic t_edge;
    logic [16:0] none[$];
    run('{8'h81, 8'h02, 8'h13}, none, 0);
    chk("err", 17'h1, {16'h0, decode_err});
    run('{8'h82, 8'h00, 8'h12, 8'h34, 8'hFF}, none, 0);
    chk("err", 17'h0, {16'h0, decode_err});
    chk("scheme", 17'h3, {15'h0, field_scheme});
    run('{8'h80, 8'h00, 8'hFF, 8'h00, 8'h41, 8'hFF, 8'hFF},
      '{17'h100FF, 17'h10041}, 0);
    chk("scheme", 17'h1, {15'h0, field_scheme});
  endtask
  // consumer stalls until the buffer refuses, then drains it
  task automatic t_stall;
    logic [7:0] b[$];
    logic [16:0] e[$];
    for (int i = 0; i < 14; i++) begin
      b.push_back(8'h20 + 8'(i));
      e.push_back(17'h00020 + 17'(i));
    end
    got.delete();
    out_ready <= 1'b0;
    fork
      src_u.send(b, 0);
    join_none
    repeat (30) @(posedge clk_sys);
    chk("stall", 17'h0, {16'h0, in_ready});
    chk("early", 17'h0, 17'(got.size()));
    out_ready <= 1'b1;
    expect_all(e);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence, reset held five cycles
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_pair();
    t_half();
    t_full();
    t_err();
    t_plain();
    t_edge();
    t_stall();
    final_report();
  end
  // watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
endmodule
